// ===== logic/pimc_core.sv
// sequencer for start-up, power modes and ratiometric conversions
// assumes one 20 MHz clock, sys_rst acts as power-up, pins asynchronous
//
// Notes on behaviour
// RULE1 - power-up cold starts at 000 after oscillator wait up to 6 s
// RULE2 - init pin low over 10 us warm starts; restart when released
// RULE3 - every start: pc 000, digit latches cleared, stack level 0
// RULE4 - cold start leaves flags, k latches, segments undefined; warm keeps
// RULE5 - any start turns switched supply off; timers keep their state (cold start here clears them)
// RULE6 - cold clears ram; warm keeps it, except a write in flight
// RULE7 - after init compare signature with A5; mismatch clears ram
// RULE8 - warm start never stops timers; only stop command does (cold start here also stops them)
// RULE9 - off by command only; keeps ram and outputs; wakes on k or init
// RULE10 - k lines all low: any rise wakes; line4 high: fall or rise wakes
// RULE11 - done by command; keeps state; wakes on k, init or timer
// RULE12 - converter powered only while a conversion runs
// RULE13 - measure operand 0..3 sets select latches 010,000,011,001
// RULE14 - supply check and calibrate set first select latch to 1
// RULE15 - switched supply on just before conversions, off right after
// RULE16 - byte operand gives conversion count and compensated choice
// RULE17 - compensated: normal plus swapped conversion, results summed
// RULE18 - 12-bit successive approximation, ratio of input to supply
// RULE19 - underrange 000, overrange FFF set negative; 000 sets zero
// RULE20 - current source on only with its latch set and supply on
// RULE21 - mode tracker: active, done, off, conversion during measures
`timescale 1ns/100ps
module pimc_core
  import pimc_pkg::*;
#(
  parameter int OSC_START_CYC = OSC_CYC
)(
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        init_request_n,
  input  wire logic [3:0]  wake_line_in,
  input  wire logic        timer_wake,
  input  wire logic        off_command,
  input  wire logic        done_command,
  input  wire logic        timer_stop_command,
  input  wire logic        timer_start_command,
  input  wire logic        measure_command,
  input  wire logic        supply_check_command,
  input  wire logic        supply_calibrate_command,
  input  wire logic [1:0]  measure_operand,
  input  wire logic [7:0]  byte_operand,
  input  wire logic [13:0] accum_in,
  input  wire logic        current_enable_write,
  input  wire logic        current_enable_value,
  input  wire logic [3:0]  k_out_write,
  input  wire logic        k_out_write_en,
  input  wire logic        cmp_high,
  input  wire logic        ram_wr_en,
  input  wire logic [5:0]  ram_addr,
  input  wire logic [7:0]  ram_wr_data,
  output      logic [7:0]  ram_rd_data,
  output      logic [11:0] program_counter,
  output      logic [1:0]  stack_level,
  output      logic        select_latch_a,
  output      logic        select_latch_b,
  output      logic        select_latch_c,
  output      logic        current_source_enable_latch,
  output      logic        current_source_on,
  output      logic        switched_sensor_supply,
  output      logic        converter_power,
  output      logic        comparator_swap,
  output      logic [11:0] sar_trial,
  output      logic [13:0] working_accumulator,
  output      logic        negative_flag,
  output      logic        positive_flag,
  output      logic        zero_flag,
  output      logic [3:0]  k_out_latch,
  output      logic        timers_running,
  output      logic        cpu_run,
  output      logic        measure_busy,
  output      logic        mode_done,
  output      logic        mode_off
);
  // -------------------------------------------------------------
  // state record
  // -------------------------------------------------------------
  typedef struct packed {
    logic [2:0]  init_s;
    logic [3:0]  k_s0;
    logic [3:0]  k_s1;
    logic [3:0]  k_s2;
    logic [3:0]  k_sleep;
    logic [27:0] cnt;
    pimc_mode_t  mode;
    logic [11:0] pc;
    logic [1:0]  stk;
    logic        sel_a;
    logic        sel_b;
    logic        sel_c;
    logic        cur_en;
    logic        supply;
    logic        swap;
    logic        check;
    logic        comp;
    logic [6:0]  conv_left;
    logic [3:0]  bit_idx;
    logic [11:0] sar;
    logic [13:0] acc;
    logic        neg;
    logic        pos;
    logic        zero;
    logic [3:0]  k_out;
    logic        tim_run;
    logic [5:0]  clr_addr;
    logic        under;
    logic        over;
  } pimc_state_t;

  pimc_state_t st_reg;
  pimc_state_t st_next;
  logic        init_low;
  logic        init_seen;
  logic [3:0]  k_now;
  logic        k_wake;
  logic        sig_ok;
  logic        ram_we;
  logic [5:0]  ram_a;
  logic [7:0]  ram_d;
  logic [11:0] res;

  // -------------------------------------------------------------
  // pin synchronisers, change counted once stages 2 and 3 agree; init release counts once either is high
  // -------------------------------------------------------------
  assign init_low  = !st_reg.init_s[1] && !st_reg.init_s[2];
  assign k_now     = st_reg.k_s1 & st_reg.k_s2;
  assign init_seen = st_reg.cnt >= 28'(INIT_MIN_CYC);
  // line4 sleeping high: falling line4 or any other rising wakes
  always_comb begin
    if (st_reg.k_sleep == 4'h8) begin
      k_wake = !(st_reg.k_s1[3] | st_reg.k_s2[3]) ||
               ((k_now[2:0]) != 3'h0); // see RULE10
    end else begin
      k_wake = (k_now & ~st_reg.k_sleep) != 4'h0; // see RULE10
    end
  end

  assign sig_ok = ram_rd_data == RAM_SIGNATURE;
  // SAR result is the trial word once all bits are decided
  assign res    = st_reg.sar;

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb begin
    st_next        = st_reg;
    ram_we         = 1'b0;
    ram_a          = ram_addr;
    ram_d          = ram_wr_data;
    st_next.init_s = {st_reg.init_s[1:0], init_request_n};
    st_next.k_s0   = wake_line_in;
    st_next.k_s1   = st_reg.k_s0;
    st_next.k_s2   = st_reg.k_s1;
    if (timer_stop_command) begin
      st_next.tim_run = 1'b0; // see RULE8
    end else if (timer_start_command) begin
      st_next.tim_run = 1'b1;
    end
    if (st_reg.mode == PM_ACTIVE && k_out_write_en) begin
      st_next.k_out = k_out_write;
    end
    if (st_reg.mode == PM_ACTIVE && current_enable_write) begin
      st_next.cur_en = current_enable_value;
    end
    case (st_reg.mode)
      PM_BOOT: begin
        // oscillator start-up wait after power-up
        st_next.cnt = st_reg.cnt + 28'd1;
        if (st_reg.cnt >= 28'(OSC_START_CYC - 1)) begin
          st_next.cnt  = '0;
          // power-up ram is garbage: clear it, never trust the signature
          st_next.mode = PM_CLEAR; // see RULE1 RULE6
        end
      end
      PM_RESTART: begin
        // hold here while the init pin stays low
        if (!init_low) begin
          st_next.mode = PM_SIGRD; // see RULE2
          st_next.cnt  = '0;
        end
      end
      PM_SIGRD: begin
        ram_a        = SIG_ADDR;
        st_next.mode = PM_SIGCHK;
      end
      PM_SIGCHK: begin
        ram_a = SIG_ADDR;
        if (sig_ok) begin
          st_next.mode = PM_ACTIVE; // see RULE7
        end else begin
          st_next.clr_addr = '0;
          st_next.mode     = PM_CLEAR;
        end
      end
      PM_CLEAR: begin
        ram_we = 1'b1;
        ram_a  = st_reg.clr_addr;
        ram_d  = 8'h00; // see RULE6
        st_next.clr_addr = st_reg.clr_addr + 6'd1;
        if (st_reg.clr_addr == RAM_LAST) begin
          st_next.mode = PM_ACTIVE; // see RULE7
        end
      end
      PM_ACTIVE: begin
        ram_we = ram_wr_en;
        if (off_command) begin
          st_next.k_sleep = k_now;
          st_next.mode    = PM_OFF; // see RULE9
        end else if (done_command) begin
          st_next.k_sleep = k_now;
          st_next.mode    = PM_DONE; // see RULE11
        end else if (measure_command || supply_check_command ||
                     supply_calibrate_command) begin
          st_next.check = supply_check_command && !measure_command;
          if (measure_command) begin
            st_next.sel_a = 1'b0; // see RULE13
            st_next.sel_b = measure_operand == SEL_IN1 ||
                            measure_operand == SEL_IN3;
            st_next.sel_c = measure_operand[1];
            st_next.comp  = byte_operand[COMP_POS]; // see RULE16
            st_next.conv_left = (byte_operand[6:0] == 7'd0) ?
                                7'd1 : byte_operand[6:0];
          end else begin
            st_next.sel_a = 1'b1; // see RULE14
            st_next.comp  = 1'b0;
            st_next.conv_left = 7'd1;
          end
          st_next.acc    = '0;
          st_next.swap   = 1'b0;
          st_next.under  = 1'b0;
          st_next.over   = 1'b0;
          st_next.supply = 1'b1; // see RULE15
          st_next.mode   = PM_SUPPLY;
        end
      end
      PM_DONE, PM_OFF: begin
        // timer wake applies to done only
        if (k_wake || (st_reg.mode == PM_DONE && timer_wake &&
                       st_reg.tim_run)) begin
          st_next.mode = PM_ACTIVE; // see RULE21
        end
      end
      PM_SUPPLY: begin
        // one cycle of settling on the freshly switched supply
        st_next.sar     = 12'h800;
        st_next.bit_idx = 4'd11;
        st_next.mode    = PM_CONV; // see RULE12
      end
      PM_CONV: begin
        // compare high keeps the trial bit, swap inverts the sense
        if (!(cmp_high ^ st_reg.swap)) begin
          st_next.sar[st_reg.bit_idx] = 1'b0; // see RULE18
        end
        if (st_reg.bit_idx != 4'd0) begin
          st_next.sar[st_reg.bit_idx - 4'd1] = 1'b1;
          st_next.bit_idx = st_reg.bit_idx - 4'd1;
        end else begin
          st_next.mode = PM_NEXT;
        end
      end
      PM_NEXT: begin
        if (res == ADC_UNDER) st_next.under = 1'b1; // see RULE19
        if (res == ADC_OVER)  st_next.over  = 1'b1; // see RULE19
        st_next.acc = st_reg.acc + 14'(res); // see RULE17
        if (st_reg.comp && !st_reg.swap) begin
          st_next.swap = 1'b1; // see RULE17
          st_next.mode = PM_SUPPLY;
        end else if (st_reg.conv_left > 7'd1) begin
          st_next.conv_left = st_reg.conv_left - 7'd1; // see RULE16
          st_next.swap      = 1'b0;
          st_next.mode      = PM_SUPPLY;
        end else begin
          st_next.supply = 1'b0; // see RULE15
          st_next.swap   = 1'b0;
          st_next.mode   = PM_ACTIVE;
          st_next.neg    = st_reg.under || st_reg.over ||
                           res == ADC_UNDER || res == ADC_OVER;
          st_next.zero   = st_reg.under || res == ADC_UNDER;
          st_next.pos    = 1'b0;
          if (st_reg.check) begin
            // compare supply reading against stored value
            st_next.pos = st_reg.acc + 14'(res) > accum_in;
            st_next.neg = st_reg.acc + 14'(res) < accum_in;
          end
        end
      end
      default: st_next.mode = PM_BOOT;
    endcase
    // warm start: pulse held past minimum width
    if (init_low) begin
      st_next.cnt = (st_reg.cnt == '1) ? st_reg.cnt : st_reg.cnt + 28'd1;
      if (init_seen && st_reg.mode != PM_BOOT) begin
        st_next.mode   = PM_RESTART; // see RULE2
        st_next.pc     = PC_START; // see RULE3
        st_next.stk    = 2'd0; // see RULE3
        st_next.sel_a  = 1'b0; // see RULE3
        st_next.sel_b  = 1'b0;
        st_next.sel_c  = 1'b0;
        st_next.cur_en = 1'b0;
        st_next.supply = 1'b0; // see RULE5
        st_next.swap   = 1'b0;
        // flags, k latches and timers deliberately untouched
        st_next.neg    = st_reg.neg; // see RULE4
        st_next.pos    = st_reg.pos; // see RULE4
        st_next.zero   = st_reg.zero; // see RULE4
        st_next.tim_run = st_reg.tim_run; // see RULE8
      end
    end else if (st_reg.mode != PM_BOOT) begin
      st_next.cnt = '0;
    end
  end

  // -------------------------------------------------------------
  // registers; cold start clears latches, pc and stack
  // -------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_reg         <= '0;
      st_reg.init_s  <= 3'h7;
      st_reg.mode    <= PM_BOOT; // see RULE1
      st_reg.pc      <= PC_START; // see RULE3
    end else begin
      st_reg <= st_next;
    end
  end

  // write in flight at init may still land in ram
  pimc_ram u_ram (
    .clock   (clock),
    .wr_en   (ram_we), // see RULE6
    .addr    (ram_a),
    .wr_data (ram_d),
    .rd_data (ram_rd_data)
  );

  // -------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------
  assign program_counter  = st_reg.pc;
  assign stack_level      = st_reg.stk;
  assign select_latch_a   = st_reg.sel_a;
  assign select_latch_b   = st_reg.sel_b;
  assign select_latch_c   = st_reg.sel_c;
  assign current_source_enable_latch = st_reg.cur_en;
  assign current_source_on = st_reg.cur_en && st_reg.supply; // see RULE20
  assign switched_sensor_supply = st_reg.supply;
  assign converter_power  = st_reg.mode == PM_CONV; // see RULE12
  assign comparator_swap  = st_reg.swap;
  assign sar_trial        = st_reg.sar;
  assign working_accumulator = st_reg.acc;
  assign negative_flag    = st_reg.neg;
  assign positive_flag    = st_reg.pos;
  assign zero_flag        = st_reg.zero;
  assign k_out_latch      = st_reg.k_out; // see RULE9
  assign timers_running   = st_reg.tim_run; // see RULE5
  assign cpu_run          = st_reg.mode == PM_ACTIVE;
  assign measure_busy     = st_reg.mode == PM_SUPPLY ||
                            st_reg.mode == PM_CONV ||
                            st_reg.mode == PM_NEXT;
  assign mode_done        = st_reg.mode == PM_DONE;
  assign mode_off         = st_reg.mode == PM_OFF;

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  sequence s_supply_up;
    st_reg.mode == PM_ACTIVE && measure_command && !off_command &&
      !done_command && !init_low;
  endsequence
  a_supply_before_conv: assert property (@(posedge clock) // see RULE15
    disable iff (sys_rst) s_supply_up |=> switched_sensor_supply)
    else $error("supply not on before conversion");
  a_conv_power_only: assert property (@(posedge clock) // see RULE12
    disable iff (sys_rst) converter_power |-> switched_sensor_supply)
    else $error("converter powered without supply");
  a_current_gate: assert property (@(posedge clock) // see RULE20
    disable iff (sys_rst) current_source_on |-> (st_reg.cur_en &&
      st_reg.supply)) else $error("current source on wrongly");
  a_sel_input3: assert property (@(posedge clock) // see RULE13
    disable iff (sys_rst) (s_supply_up and (measure_operand == SEL_IN3)) |=>
      !select_latch_a && select_latch_b && select_latch_c)
    else $error("select latches wrong for input 3");
  a_warm_supply_off: assert property (@(posedge clock) // see RULE5
    disable iff (sys_rst) init_low && init_seen && st_reg.mode != PM_BOOT
      |=> !switched_sensor_supply && program_counter == PC_START)
    else $error("warm start left supply on");
  a_timer_kept: assert property (@(posedge clock) // see RULE8
    disable iff (sys_rst) !timer_stop_command && !timer_start_command
      |=> timers_running == $past(timers_running))
    else $error("timer state changed without command");
  a_off_k_only: assert property (@(posedge clock) // see RULE9
    disable iff (sys_rst) mode_off && !k_wake && !init_low |=> mode_off)
    else $error("off mode left without wake");
  a_zero_sets_neg: assert property (@(posedge clock) // see RULE19
    disable iff (sys_rst) zero_flag && !$stable(zero_flag) |-> negative_flag
      || st_reg.check) else $error("zero result without negative");
endmodule // pimc_core

// ===== logic/pimc_pkg.sv
// package for the power, init and measure sequencer
// assumes a 20 MHz clock and a synchronous active-high reset
package pimc_pkg;
  localparam int          CLK_HZ          = 20000000;
  localparam int          INIT_MIN_NS     = 10000;
  localparam int          INIT_MIN_CYC    = (INIT_MIN_NS * 20 + 999) / 1000;
  localparam int          OSC_MAX_S       = 6;
  localparam int          OSC_CYC         = OSC_MAX_S * CLK_HZ;
  localparam logic [11:0] PC_START        = 12'h000;
  localparam logic [7:0]  RAM_SIGNATURE   = 8'hA5;
  localparam logic [11:0] ADC_UNDER       = 12'h000;
  localparam logic [11:0] ADC_OVER        = 12'hFFF;
  localparam int          RAM_WORDS       = 64;
  localparam int          RAM_AW          = 6;
  localparam logic [5:0]  SIG_ADDR        = 6'h3F;
  localparam logic [5:0]  RAM_LAST        = 6'h3F;
  localparam int          SAR_BITS        = 12;
  localparam int          CNT_POS         = 0;
  localparam int          COMP_POS        = 7;
  typedef enum logic [1:0] {
    SEL_IN1, SEL_IN2, SEL_IN3, SEL_IN4
  } pimc_sel_t;
  typedef enum {
    PM_BOOT, PM_RESTART, PM_SIGRD, PM_SIGCHK, PM_CLEAR, PM_ACTIVE,
    PM_DONE, PM_OFF, PM_SUPPLY, PM_CONV, PM_NEXT
  } pimc_mode_t;
endpackage

// ===== logic/pimc_ram.sv
// small single-port ram holding the working data
// assumes one clock; read data comes out of a register
`timescale 1ns/100ps
module pimc_ram
  import pimc_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              wr_en,
  input  wire logic [RAM_AW-1:0] addr,
  input  wire logic [7:0]        wr_data,
  output      logic [7:0]        rd_data
);
  logic [7:0] mem_reg [RAM_WORDS];
  // no reset: contents must survive warm starts
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem_reg[addr] <= wr_data;
    end
    rd_data <= mem_reg[addr];
  end
endmodule // pimc_ram

// ===== bench/pimc_sensor.sv
// sensor and comparator model on the analog side of the sequencer
// assumes one trial value per clock while the converter is powered
`timescale 1ns/100ps
module pimc_sensor #(
  parameter int OFS = 2
)(
  input  wire logic               clock,
  input  wire logic               converter_power,
  input  wire logic               comparator_swap,
  input  wire logic [11:0]        sar_trial,
  input  wire logic signed [15:0] level,
  output      logic               cmp_high
);
  logic               toggle_reg = 1'b0;
  logic signed [16:0] eff;

  // unpowered comparator output is garbage, never a steady last value
  always @(posedge clock) toggle_reg <= ~toggle_reg;

  always_comb begin
    // offset changes sign with swapped inputs, so a summed pair cancels
    eff = comparator_swap ? level - OFS : level + OFS;
    // input and trial share the supply ratio; input sits OFS steps up
    // swapped inputs also turn the output's sense around
    if (converter_power)
      cmp_high = comparator_swap ^
                 (eff >= $signed({5'h00, sar_trial}));
    else
      cmp_high = toggle_reg;
  end
endmodule // pimc_sensor

// ===== bench/tb_pimc_core.sv
// self-checking bench for the power, init and measure sequencer
// assumes the core with a 20-cycle oscillator wait and the sensor model
`timescale 1ns/100ps
module tb_pimc_core
  import pimc_pkg::*;
;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int         OFS = 2;
  localparam logic [2:0] SEL [4] = '{3'h2, 3'h0, 3'h3, 3'h1};
  typedef struct {
    logic [13:0] acc;
    logic        neg;
    logic        zero;
    int          kind;
  } pimc_exp_t;
  pimc_exp_t          exp_q [$];
  int                 n_mismatch = 0, compares = 0, cycles = 0;
  logic               clock = 1'b0, sys_rst = 1'b1, init_request_n = 1'b1;
  logic [7:0]         cmd = 8'h00, byte_operand = 8'h01, ram_wr_data = 8'h00;
  logic [3:0]         wake_line_in = 4'h0, k_out_write = 4'h0;
  logic [1:0]         measure_operand = 2'h0;
  logic [13:0]        accum_in = 14'h0000;
  logic [5:0]         ram_addr = 6'h00;
  logic               current_enable_write = 1'b0, current_enable_value = 1'b0;
  logic               k_out_write_en = 1'b0, ram_wr_en = 1'b0, busy_q = 1'b0;
  logic               cen_exp = 1'b0;
  logic signed [15:0] level = 16'h0000;
  logic [7:0]         ram_rd_data;
  logic [11:0]        program_counter, sar_trial;
  logic [1:0]         stack_level;
  logic [13:0]        working_accumulator;
  logic [3:0]         k_out_latch;
  logic select_latch_a, select_latch_b, select_latch_c, cmp_high;
  logic current_source_enable_latch, current_source_on, switched_sensor_supply;
  logic converter_power, comparator_swap, negative_flag, positive_flag;
  logic zero_flag, timers_running, cpu_run, measure_busy, mode_done, mode_off;

  always #25 clock = ~clock;

  pimc_core #(.OSC_START_CYC(20)) dut (
    .clock, .sys_rst, .init_request_n, .wake_line_in, .timer_wake(cmd[7]),
    .off_command(cmd[0]), .done_command(cmd[1]),
    .timer_stop_command(cmd[2]), .timer_start_command(cmd[3]),
    .measure_command(cmd[4]), .supply_check_command(cmd[5]),
    .supply_calibrate_command(cmd[6]), .measure_operand, .byte_operand,
    .accum_in, .current_enable_write, .current_enable_value, .k_out_write,
    .k_out_write_en, .cmp_high, .ram_wr_en, .ram_addr, .ram_wr_data,
    .ram_rd_data, .program_counter, .stack_level, .select_latch_a,
    .select_latch_b, .select_latch_c, .current_source_enable_latch,
    .current_source_on, .switched_sensor_supply, .converter_power,
    .comparator_swap, .sar_trial, .working_accumulator, .negative_flag,
    .positive_flag, .zero_flag, .k_out_latch, .timers_running, .cpu_run,
    .measure_busy, .mode_done, .mode_off);

  pimc_sensor #(.OFS(OFS)) sensor (.clock, .converter_power, .comparator_swap,
    .sar_trial, .level, .cmp_high);

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // bounded wait for cpu_run or, with busy set, for measure_busy
  task automatic wait_hi(input bit busy);
    int n;
    n = 0;
    while (((busy ? measure_busy : cpu_run) !== 1'b1) && n < 400) begin
      @(negedge clock);
      n++;
    end
    if (n == 400) chk(32'h0, 32'h1);
  endtask

  task automatic pulse(input int i);
    @(negedge clock);
    cmd[i] = 1'b1;
    @(negedge clock);
    cmd[i] = 1'b0;
  endtask

  task automatic ram_wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clock);
    {ram_wr_en, ram_addr, ram_wr_data} = {1'b1, a, d};
    @(negedge clock);
    ram_wr_en = 1'b0;
  endtask

  task automatic ram_chk(input logic [5:0] a, input logic [7:0] d);
    @(negedge clock);
    ram_addr = a;
    repeat (2) @(negedge clock);
    chk(ram_rd_data, d);
  endtask

  // init pin held well past its minimum, then released
  task automatic warm;
    @(negedge clock);
    init_request_n = 1'b0;
    repeat (220) @(negedge clock);
    init_request_n = 1'b1;
    repeat (6) @(negedge clock);
    wait_hi(0);
  endtask

  task automatic measure(input logic [1:0] op, input logic [7:0] bo,
                         input int lvl, input int kind);
    pimc_exp_t e;
    int        v, n;
    v = lvl + OFS;
    if (v < 0) v = 0;
    if (v > 4095) v = 4095;
    n = (bo[6:0] == 7'h00) ? 1 : int'(bo[6:0]);
    e.acc = bo[7] ? 14'(2 * lvl * n) : 14'(v * n);
    e.neg = (v == 0 || v == 4095);
    e.zero = (v == 0);
    e.kind = kind;
    exp_q.push_back(e);
    level = 16'(lvl);
    measure_operand = op;
    byte_operand = bo;
    pulse(4);
    wait_hi(1);
    chk({select_latch_a, select_latch_b, select_latch_c}, SEL[op]);
    chk(switched_sensor_supply, 1'b1);
    chk(current_source_on, cen_exp);
    wait_hi(0);
    chk(switched_sensor_supply, 1'b0);
    chk(converter_power, 1'b0);
  endtask

  // result watcher: oldest note is compared when a measure ends
  always @(posedge clock) begin
    pimc_exp_t e;
    busy_q <= measure_busy;
    if (busy_q === 1'b1 && measure_busy === 1'b0) begin
      if (exp_q.size() == 0) chk(32'h0, 32'h1);
      else begin
        e = exp_q.pop_front();
        if (e.kind > 0) chk(working_accumulator, e.acc);
        if (e.kind > 1) chk({negative_flag, zero_flag}, {e.neg, e.zero});
      end
    end
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 10000) begin
      n_mismatch++;
      conclude();
    end
  end

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h7975));
    repeat (12) @(negedge clock);
    sys_rst = 1'b0;
    wait_hi(0);
    chk(program_counter, PC_START);
    chk(stack_level, 2'h0);
    chk(switched_sensor_supply, 1'b0);
    ram_wr(SIG_ADDR, RAM_SIGNATURE);
    ram_wr(6'h05, 8'h77);
    @(negedge clock);
    {k_out_write_en, k_out_write} = {1'b1, 4'hA};
    {current_enable_write, current_enable_value} = 2'h3;
    @(negedge clock);
    {k_out_write_en, current_enable_write} = 2'h0;
    pulse(3);
    chk(current_source_on, 1'b0);
    warm();
    chk(program_counter, PC_START);
    chk(stack_level, 2'h0);
    chk(current_source_enable_latch, 1'b0);
    chk(k_out_latch, 4'hA);
    chk(timers_running, 1'b1);
    ram_chk(6'h05, 8'h77);
    ram_wr(SIG_ADDR, 8'h00);
    warm();
    ram_chk(6'h05, 8'h00);
    for (int op = 0; op < 4; op++)
      measure(2'(op), 8'h01, $urandom_range(4000, 16), 2);
    @(negedge clock);
    {current_enable_write, current_enable_value} = 2'h3;
    cen_exp = 1'b1;
    @(negedge clock);
    current_enable_write = 1'b0;
    measure(2'h2, 8'h81, $urandom_range(4000, 16), 1);
    measure(2'h3, 8'h03, $urandom_range(4000, 16), 1);
    measure(2'h0, 8'h01, -50, 2);
    measure(2'h1, 8'h01, 5000, 2);
    // level still overranged, so the internal reading is full scale
    for (int i = 5; i < 7; i++) begin
      exp_q.push_back('{14'hFFF, 1'b0, 1'b0, 1});
      accum_in = 14'($urandom);
      pulse(i);
      wait_hi(1);
      chk(select_latch_a, 1'b1);
      wait_hi(0);
      if (i == 5)
        chk({positive_flag, negative_flag},
            {accum_in < 14'hFFF, accum_in > 14'hFFF});
    end
    pulse(2);
    @(negedge clock);
    chk(timers_running, 1'b0);
    pulse(0);
    @(negedge clock);
    chk({mode_off, cpu_run}, 2'h2);
    repeat (10) @(negedge clock);
    wake_line_in = 4'h1 << $urandom_range(2, 0);
    wait_hi(0);
    chk(mode_off, 1'b0);
    wake_line_in = 4'h8;
    repeat (6) @(negedge clock);
    pulse(0);
    repeat (10) @(negedge clock);
    chk(mode_off, 1'b1);
    wake_line_in = 4'h0;
    wait_hi(0);
    chk(mode_off, 1'b0);
    pulse(1);
    @(negedge clock);
    chk({mode_done, cpu_run}, 2'h2);
    // timers are stopped, so a timer wake must not count yet
    pulse(7);
    @(negedge clock);
    chk(mode_done, 1'b1);
    pulse(3);
    pulse(7);
    wait_hi(0);
    chk(mode_done, 1'b0);
    ram_wr(SIG_ADDR, RAM_SIGNATURE);
    ram_wr(6'h05, 8'h77);
    sys_rst = 1'b1;
    repeat (12) @(negedge clock);
    sys_rst = 1'b0;
    wait_hi(0);
    ram_chk(6'h05, 8'h00);
    chk(program_counter, PC_START);
    conclude();
  end
endmodule // tb_pimc_core
